/* File: pal_pkg.sv */
// constants, register map and field layout for the palette pixel port
package pal_pkg;
    // ************************************************************
    // register map, byte addresses on the apb
    // ************************************************************
    localparam int ADDR_W = 12;
    localparam logic [11:0] READ_MASK_OFS = 12'h000;
    localparam logic [11:0] BLINK_MASK_OFS = 12'h004;
    localparam logic [11:0] COMMAND_OFS = 12'h008;
    localparam logic [11:0] STATUS_OFS = 12'h00C;
    localparam logic [11:0] OVERLAY_BASE_OFS = 12'h010;
    localparam logic [11:0] PALETTE_BASE_OFS = 12'h400;
    localparam logic [7:0] READ_MASK_RST = 8'h00;
    localparam logic [7:0] BLINK_MASK_RST = 8'h00;
    localparam logic [7:0] COMMAND_RST = 8'h00;

    // ************************************************************
    // command and status register fields
    // ************************************************************
    localparam int OVL_LO_DISPLAY_EN_POS = 0;
    localparam int OVL_HI_DISPLAY_EN_POS = 1;
    localparam int OVL_LO_BLINK_EN_POS = 2;
    localparam int OVL_HI_BLINK_EN_POS = 3;
    localparam int BLINK_RATE_POS = 4;
    localparam int PALETTE_ENABLE_POS = 6;
    localparam int MUX_RATIO_SELECT_POS = 7;
    localparam int RETRACE_STATUS_POS = 0;
    localparam int BLINK_ON_STATUS_POS = 1;

    // ************************************************************
    // colour word layout and timing
    // ************************************************************
    localparam int RED_LSB = 16;
    localparam int GREEN_LSB = 8;
    localparam int BLUE_LSB = 0;
    localparam logic [8:0] RETRACE_GROUPS = 9'h100;
    localparam int FRAME_CNT_W = 7;

    typedef logic [1:0] blink_rate_t;
    typedef enum logic [1:0] {
        RATE_16_48 = 2'b00,
        RATE_16_16 = 2'b01,
        RATE_32_32 = 2'b10,
        RATE_64_64 = 2'b11
    } blink_rate_e_t;
endpackage

/* File: pixel_capture.sv */
// pixel group capture, internal load generation and pixel multiplexer
`timescale 1ns/1ps
`default_nettype none
module pixel_capture #(
    parameter int LANES = 5,
    parameter int PW = 8
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic strobe_n,
    input wire logic mux5,
    input wire logic [LANES*PW-1:0] planes,
    input wire logic [LANES-1:0] ovl_lo,
    input wire logic [LANES-1:0] ovl_hi,
    input wire logic sync_n,
    input wire logic blank_n,
    output logic load_pulse,
    output logic [PW-1:0] pix_plane,
    output logic [1:0] pix_ovl,
    output logic grp_sync_n,
    output logic grp_blank_n
);
    import pal_pkg::*;
    localparam int SW = $clog2(LANES);

    typedef struct packed {
        logic strobe_q;
        logic cap_q;
        logic [LANES*PW-1:0] p1_q;
        logic [LANES-1:0] lo1_q;
        logic [LANES-1:0] hi1_q;
        logic sync1_q;
        logic blank1_q;
        logic load_q;
        logic [LANES*PW-1:0] p2_q;
        logic [LANES-1:0] lo2_q;
        logic [LANES-1:0] hi2_q;
        logic sync2_q;
        logic blank2_q;
        logic [SW-1:0] sel_q;
        logic [PW-1:0] plane_q;
        logic [1:0] ovl_q;
        logic sync_q;
        logic blank_q;
    } cap_state_t;

    cap_state_t s_q;
    cap_state_t s_d;

    always_comb begin
        logic rise;
        logic [SW-1:0] last;
        rise = 1'b0;
        last = '0;
        s_d = s_q;
        rise = strobe_n & ~s_q.strobe_q;
        last = mux5 ? SW'(LANES - 1) : SW'(LANES - 2);
        s_d.strobe_q = strobe_n;
        s_d.cap_q = rise;
        // the whole group, sync and blank included, is taken at the strobe's rising edge
        if (rise) begin // RULE1 RULE4
            s_d.p1_q = planes;
            s_d.lo1_q = ovl_lo;
            s_d.hi1_q = ovl_hi;
            s_d.sync1_q = sync_n; // RULE3
            s_d.blank1_q = blank_n; // RULE3
            if (!mux5) begin // RULE19
                s_d.p1_q[(LANES-1)*PW +: PW] = '0;
                s_d.lo1_q[LANES-1] = 1'b0;
                s_d.hi1_q[LANES-1] = 1'b0;
            end
        end
        // load follows the captured edge by one clock; relocks the multiplexer
        s_d.load_q = s_q.cap_q; // RULE6
        if (s_q.cap_q) begin // RULE6
            s_d.p2_q = s_q.p1_q;
            s_d.lo2_q = s_q.lo1_q;
            s_d.hi2_q = s_q.hi1_q;
            s_d.sync2_q = s_q.sync1_q;
            s_d.blank2_q = s_q.blank1_q;
            s_d.sel_q = '0;
        end else if (s_q.sel_q >= last) begin // RULE2
            s_d.sel_q = '0;
        end else begin
            s_d.sel_q = s_q.sel_q + 1'b1;
        end
        // one pixel per clock, lane a first
        s_d.plane_q = s_q.p2_q[s_q.sel_q*PW +: PW]; // RULE7 RULE2
        s_d.ovl_q = {s_q.hi2_q[s_q.sel_q], s_q.lo2_q[s_q.sel_q]};
        s_d.sync_q = s_q.sync2_q;
        s_d.blank_q = s_q.blank2_q;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign load_pulse = s_q.load_q;
    assign pix_plane = s_q.plane_q;
    assign pix_ovl = s_q.ovl_q;
    assign grp_sync_n = s_q.sync_q;
    assign grp_blank_n = s_q.blank_q;
endmodule // pixel_capture
`default_nettype wire

/* File: blink_timer.sv */
// vertical retrace detection and blink phase timer
`timescale 1ns/1ps
`default_nettype none
module blink_timer (
    input wire logic clk,
    input wire logic rst,
    input wire logic load_pulse,
    input wire logic blank_n,
    input wire pal_pkg::blink_rate_t rate,
    output logic retrace,
    output logic blink_on
);
    import pal_pkg::*;

    typedef struct packed {
        logic [8:0] low_cnt_q;
        logic [FRAME_CNT_W-1:0] frame_q;
        logic on_q;
    } blink_state_t;

    blink_state_t s_q;
    blink_state_t s_d;

    function automatic logic phase_on(input blink_rate_t r, input logic [FRAME_CNT_W-1:0] f);
        case (r)
            RATE_16_48: phase_on = (f[5:4] == 2'b00);
            RATE_16_16: phase_on = ~f[4];
            RATE_32_32: phase_on = ~f[5];
            RATE_64_64: phase_on = ~f[6];
            default: phase_on = 1'b1;
        endcase
    endfunction

    always_comb begin
        logic [FRAME_CNT_W-1:0] nf;
        nf = '0;
        s_d = s_q;
        nf = s_q.frame_q + 1'b1;
        if (load_pulse) begin
            if (blank_n) begin
                s_d.low_cnt_q = '0;
            end else if (s_q.low_cnt_q < RETRACE_GROUPS) begin // RULE11
                s_d.low_cnt_q = s_q.low_cnt_q + 1'b1;
                // blink state moves only once per frame, inside retrace
                if (s_q.low_cnt_q == RETRACE_GROUPS - 9'h001) begin // RULE10
                    s_d.frame_q = nf;
                    s_d.on_q = phase_on(rate, nf); // RULE20
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign retrace = (s_q.low_cnt_q == RETRACE_GROUPS); // RULE11
    assign blink_on = s_q.on_q;
endmodule // blink_timer
`default_nettype wire

/* File: palette_pixel_port.sv */
// palette pixel port: group capture, colour selection and apb registers
//
// Contract
// (RULE1) each load strobe rise captures a group: planes, overlay, sync, blank
// (RULE2) pixels leave in input order; the group repeats after the last
// (RULE3) sync and blank change only per captured group
// (RULE4) capture happens on the strobe rising edge, no phase to clock needed
// (RULE5) frame buffer may derive the strobe by dividing the clock
// (RULE6) internal load pulse follows the strobe by one to four clocks
// (RULE7) second stage is sent one pixel per clock
// (RULE8) frame buffer raises strobe exactly every four or five clocks
// (RULE9) every clock one pixel passes through the mask and command logic
// (RULE10) blink state changes only during vertical retrace
// (RULE11) retrace is blank low for 256 consecutive groups
// (RULE12) palette enable with both overlay selects low uses palette entry
// (RULE13) otherwise the overlay register chosen by the select is used
// (RULE14) plane bit zero is the palette address lsb
// (RULE15) 24-bit colour leaves as three 8-bit values each clock
// (RULE16) blank low forces blanking and zero data; sync low drops pedestal
// (RULE17) sync only on the green channel
// (RULE18) host write over a displayed location disturbs at most one pixel
// (RULE19) mux ratio bit selects 4:1 or 5:1; 4:1 ignores fifth lane
// (RULE20) blink rate field picks 16/48, 16/16, 32/32, 64/64 frames
// (RULE21) planes are anded with the read mask
// (RULE22) blink-masked planes read zero during the off phase
// (RULE23) delay from multiplexer to converter inputs is fixed for every pixel
//
// The placing of the registers and the APB slave port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module palette_pixel_port #(
    parameter int LANES = 5,
    parameter int PW = 8
) (
    input wire logic MCLK,
    input wire logic RST,
    input wire logic PIXEL_GROUP_LOAD_STROBE_N,
    input wire logic [LANES*PW-1:0] PIXEL_PLANE_BITS,
    input wire logic [LANES-1:0] OVERLAY_SELECT_LOW,
    input wire logic [LANES-1:0] OVERLAY_SELECT_HIGH,
    input wire logic SYNC_N,
    input wire logic VIDEO_BLANK_INPUT_N,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [pal_pkg::ADDR_W-1:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    output logic [7:0] RED_CURRENT_OUTPUT,
    output logic [7:0] GREEN_CURRENT_OUTPUT,
    output logic [7:0] BLUE_CURRENT_OUTPUT,
    output logic GREEN_SYNC_N,
    output logic DAC_BLANK_N
);
    import pal_pkg::*;

    // ************************************************************
    // state
    // ************************************************************
    typedef struct packed {
        logic [7:0] read_mask_q;
        logic [7:0] blink_mask_q;
        logic [7:0] command_q;
        logic [3:0][23:0] overlay_q;
        logic [255:0][23:0] palette_q;
        logic pready_q;
        logic pslverr_q;
        logic [31:0] prdata_q;
        logic [7:0] addr_q;
        logic [1:0] ovl_q;
        logic use_pal_q;
        logic sync_a_q;
        logic blank_a_q;
        logic [23:0] colour_q;
        logic sync_q;
        logic blank_q;
    } top_state_t;

    top_state_t s_q;
    top_state_t s_d;

    logic load_pulse;
    logic [PW-1:0] pix_plane;
    logic [1:0] pix_ovl;
    logic grp_sync_n;
    logic grp_blank_n;
    logic retrace;
    logic blink_on;

    function automatic logic is_palette(input logic [ADDR_W-1:0] a);
        is_palette = (a[ADDR_W-1:10] == PALETTE_BASE_OFS[ADDR_W-1:10]);
    endfunction

    function automatic logic is_overlay(input logic [ADDR_W-1:0] a);
        is_overlay = (a[ADDR_W-1:4] == OVERLAY_BASE_OFS[ADDR_W-1:4]);
    endfunction

    // ************************************************************
    // submodules
    // ************************************************************
    pixel_capture #(
        .LANES(LANES),
        .PW(PW)
    ) u_capture (
        .clk(MCLK),
        .rst(RST),
        .strobe_n(PIXEL_GROUP_LOAD_STROBE_N),
        .mux5(s_q.command_q[MUX_RATIO_SELECT_POS]),
        .planes(PIXEL_PLANE_BITS),
        .ovl_lo(OVERLAY_SELECT_LOW),
        .ovl_hi(OVERLAY_SELECT_HIGH),
        .sync_n(SYNC_N),
        .blank_n(VIDEO_BLANK_INPUT_N),
        .load_pulse(load_pulse),
        .pix_plane(pix_plane),
        .pix_ovl(pix_ovl),
        .grp_sync_n(grp_sync_n),
        .grp_blank_n(grp_blank_n)
    );

    blink_timer u_blink (
        .clk(MCLK),
        .rst(RST),
        .load_pulse(load_pulse),
        .blank_n(grp_blank_n),
        .rate(s_q.command_q[BLINK_RATE_POS +: 2]),
        .retrace(retrace),
        .blink_on(blink_on)
    );

    // ************************************************************
    // next state
    // ************************************************************
    always_comb begin
        logic acc;
        logic [7:0] cmd;
        logic [7:0] masked;
        logic lo;
        logic hi;
        logic [23:0] col;
        acc = 1'b0;
        cmd = '0;
        masked = '0;
        lo = 1'b0;
        hi = 1'b0;
        col = '0;
        s_d = s_q;
        cmd = s_q.command_q;

        // apb: answer one cycle into the access phase, write on completion
        acc = PSEL & PENABLE;
        s_d.pready_q = acc & ~s_q.pready_q;
        // the error flag stands only with ready, never beyond the transfer
        s_d.pslverr_q = 1'b0;
        if (acc && !s_q.pready_q) begin
            s_d.prdata_q = '0;
            if (is_palette(PADDR)) begin
                s_d.prdata_q[23:0] = s_q.palette_q[PADDR[9:2]];
            end else if (is_overlay(PADDR)) begin
                s_d.prdata_q[23:0] = s_q.overlay_q[PADDR[3:2]];
            end else if (PADDR == READ_MASK_OFS) begin
                s_d.prdata_q[7:0] = s_q.read_mask_q;
            end else if (PADDR == BLINK_MASK_OFS) begin
                s_d.prdata_q[7:0] = s_q.blink_mask_q;
            end else if (PADDR == COMMAND_OFS) begin
                s_d.prdata_q[7:0] = s_q.command_q;
            end else if (PADDR == STATUS_OFS) begin
                s_d.prdata_q[RETRACE_STATUS_POS] = retrace;
                s_d.prdata_q[BLINK_ON_STATUS_POS] = blink_on;
            end else begin
                s_d.pslverr_q = 1'b1;
            end
        end
        // a write lands on one edge, so a refresh read of the same entry sees
        // either old or new colour and only the pixel on that edge can differ
        if (acc && s_q.pready_q && PWRITE) begin // RULE18
            if (is_palette(PADDR)) begin
                s_d.palette_q[PADDR[9:2]] = PWDATA[23:0];
            end else if (is_overlay(PADDR)) begin
                s_d.overlay_q[PADDR[3:2]] = PWDATA[23:0];
            end else if (PADDR == READ_MASK_OFS) begin
                s_d.read_mask_q = PWDATA[7:0];
            end else if (PADDR == BLINK_MASK_OFS) begin
                s_d.blink_mask_q = PWDATA[7:0];
            end else if (PADDR == COMMAND_OFS) begin
                s_d.command_q = PWDATA[7:0];
            end
        end

        // stage a: masking and selection, one pixel per clock
        masked = pix_plane & s_q.read_mask_q; // RULE9 RULE21
        masked = masked & ~(s_q.blink_mask_q & {8{~blink_on}}); // RULE22
        lo = pix_ovl[0] & cmd[OVL_LO_DISPLAY_EN_POS] & ~(cmd[OVL_LO_BLINK_EN_POS] & ~blink_on);
        hi = pix_ovl[1] & cmd[OVL_HI_DISPLAY_EN_POS] & ~(cmd[OVL_HI_BLINK_EN_POS] & ~blink_on);
        s_d.addr_q = masked; // RULE14
        s_d.ovl_q = {hi, lo};
        s_d.use_pal_q = cmd[PALETTE_ENABLE_POS] & ~hi & ~lo; // RULE12 RULE13
        s_d.sync_a_q = grp_sync_n;
        s_d.blank_a_q = grp_blank_n;

        // stage b: colour lookup; every pixel takes the same two stages
        if (s_q.use_pal_q) begin // RULE12 RULE23
            col = s_q.palette_q[s_q.addr_q];
        end else begin
            col = s_q.overlay_q[s_q.ovl_q]; // RULE13
        end
        if (!s_q.blank_a_q) begin // RULE16
            col = '0;
        end
        s_d.colour_q = col; // RULE15
        s_d.sync_q = s_q.sync_a_q; // RULE16 RULE17
        s_d.blank_q = s_q.blank_a_q;
    end

    always_ff @(posedge MCLK) begin
        if (RST) begin
            s_q <= '0;
            s_q.read_mask_q <= READ_MASK_RST;
            s_q.blink_mask_q <= BLINK_MASK_RST;
            s_q.command_q <= COMMAND_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    assign PRDATA = s_q.prdata_q;
    assign PREADY = s_q.pready_q;
    assign PSLVERR = s_q.pslverr_q;
    assign RED_CURRENT_OUTPUT = s_q.colour_q[RED_LSB +: 8]; // RULE15
    assign GREEN_CURRENT_OUTPUT = s_q.colour_q[GREEN_LSB +: 8];
    assign BLUE_CURRENT_OUTPUT = s_q.colour_q[BLUE_LSB +: 8];
    // red and blue carry no sync; only this pin offsets green
    assign GREEN_SYNC_N = s_q.sync_q; // RULE17
    assign DAC_BLANK_N = s_q.blank_q;
endmodule // palette_pixel_port
`default_nettype wire

/* File: palette_pixel_port_assertions.sv */
// concurrent checks on the ports of the palette pixel port
`timescale 1ns/1ps
`default_nettype none
module palette_pixel_port_assertions #(
    parameter int LANES = 5,
    parameter int PW = 8
) (
    input wire logic MCLK,
    input wire logic RST,
    input wire logic PIXEL_GROUP_LOAD_STROBE_N,
    input wire logic [LANES*PW-1:0] PIXEL_PLANE_BITS,
    input wire logic [LANES-1:0] OVERLAY_SELECT_LOW,
    input wire logic [LANES-1:0] OVERLAY_SELECT_HIGH,
    input wire logic SYNC_N,
    input wire logic VIDEO_BLANK_INPUT_N,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [pal_pkg::ADDR_W-1:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [31:0] PRDATA,
    input wire logic PREADY,
    input wire logic PSLVERR,
    input wire logic [7:0] RED_CURRENT_OUTPUT,
    input wire logic [7:0] GREEN_CURRENT_OUTPUT,
    input wire logic [7:0] BLUE_CURRENT_OUTPUT,
    input wire logic GREEN_SYNC_N,
    input wire logic DAC_BLANK_N
);
    import pal_pkg::*;
    // ****************************************
    // bus answer and video level checks
    // ****************************************
    default clocking @(posedge MCLK); endclocking
    default disable iff (RST);
    AST_READY_WAIT: assert property ($rose(PSEL && PENABLE) |-> !PREADY ##1 PREADY)
        else $error("bus answer not after one wait state");
    AST_READY_PULSE: assert property (PREADY |=> !PREADY)
        else $error("bus ready longer than one cycle");
    AST_ERR_DATA: assert property (PSLVERR |-> PREADY && PRDATA == 32'h0)
        else $error("bus error without ready or with data");
    AST_BLANK_ZERO: assert property (!DAC_BLANK_N |-> {RED_CURRENT_OUTPUT, GREEN_CURRENT_OUTPUT, BLUE_CURRENT_OUTPUT} == 24'h0)
        else $error("colour present while blanked");
    AST_BLANK_LATENCY: assert property ($changed(DAC_BLANK_N) |-> DAC_BLANK_N == $past(VIDEO_BLANK_INPUT_N, 5))
        else $error("blank level not from captured group");
    AST_SYNC_LATENCY: assert property ($changed(GREEN_SYNC_N) |-> GREEN_SYNC_N == $past(SYNC_N, 5))
        else $error("green sync not from captured group");
    AST_BLANK_HOLD: assert property ($changed(DAC_BLANK_N) |=> $stable(DAC_BLANK_N) [*3])
        else $error("blank changed inside a group");
    AST_SYNC_HOLD: assert property ($changed(GREEN_SYNC_N) |=> $stable(GREEN_SYNC_N) [*3])
        else $error("sync changed inside a group");
endmodule // palette_pixel_port_assertions
bind palette_pixel_port palette_pixel_port_assertions #(.LANES(LANES), .PW(PW)) port_checks_inst (
    .MCLK(MCLK), .RST(RST), .PIXEL_GROUP_LOAD_STROBE_N(PIXEL_GROUP_LOAD_STROBE_N),
    .PIXEL_PLANE_BITS(PIXEL_PLANE_BITS), .OVERLAY_SELECT_LOW(OVERLAY_SELECT_LOW),
    .OVERLAY_SELECT_HIGH(OVERLAY_SELECT_HIGH), .SYNC_N(SYNC_N),
    .VIDEO_BLANK_INPUT_N(VIDEO_BLANK_INPUT_N), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .RED_CURRENT_OUTPUT(RED_CURRENT_OUTPUT), .GREEN_CURRENT_OUTPUT(GREEN_CURRENT_OUTPUT),
    .BLUE_CURRENT_OUTPUT(BLUE_CURRENT_OUTPUT), .GREEN_SYNC_N(GREEN_SYNC_N),
    .DAC_BLANK_N(DAC_BLANK_N));
`default_nettype wire

/* File: frame_buffer_model.sv */
// frame buffer model: divided load strobe and random pixel groups
`timescale 1ns/1ps
`default_nettype none
module frame_buffer_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic five,
    input wire logic retrace,
    output logic strobe_n,
    output logic [39:0] planes,
    output logic [4:0] ovl_lo,
    output logic [4:0] ovl_hi,
    output logic sync_n,
    output logic blank_n
);
    integer seed = 32'hd5ad;
    int ph = 0;
    // ****************************************
    // strobe divider and group data
    // ****************************************
    // a plain counter divide, so the strobe period never wavers
    always @(posedge clk) begin
        ph <= (rst || ph >= (five ? 4 : 3)) ? 0 : ph + 1;
        strobe_n <= (ph == 1 || ph == 2);
        if (rst) begin
            {planes, ovl_lo, ovl_hi, sync_n, blank_n} <= '0;
        end else if (ph == 1) begin
            planes <= 40'({$random(seed), $random(seed)});
            ovl_lo <= 5'($random(seed));
            ovl_hi <= 5'($random(seed));
            sync_n <= ($random(seed) & 3) != 0;
            // blank held low for a whole retrace when asked
            blank_n <= !retrace && (($random(seed) & 3) != 0);
        end
    end
endmodule // frame_buffer_model
`default_nettype wire

/* File: palette_pixel_port_test.sv */
// self-checking bench: frame buffer model, apb master and colour reference
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin n_errors++; $display("wrong value %s expected %h seen %h", nm, e, g); end end
module palette_pixel_port_test;
    import pal_pkg::*;
    typedef struct {int due; logic [23:0] col; logic sy; logic bl;} exp_t;
    logic MCLK = 0;
    logic RST = 1;
    logic PSEL = 0;
    logic PENABLE = 0;
    logic PWRITE = 0;
    logic [11:0] PADDR = 0;
    logic [31:0] PWDATA = 0;
    logic five = 0;
    logic retr = 0;
    logic chk = 0;
    logic sp = 0;
    logic stb_n, sy_n, bl_n, rdy, err, gsync_n, dblank_n, er;
    logic [39:0] planes;
    logic [4:0] lo, hi;
    logic [31:0] prdata, rd;
    logic [7:0] red, green, blue;
    int n_errors = 0, n_tests = 0, cyc = 0, cmd = 0, rm = 0, bm = 0;
    int pal [256];
    int ovr [4];
    bit bon = 0;
    exp_t q [$];
    integer seed = 32'hd5ad;
    int cfg [5][3] = '{'{8'h43, 8'hFF, 8'h0F}, '{8'hD3, 8'h5A, 8'h00}, '{8'h23, 8'hFF, 8'h00},
        '{8'h8F, 8'hFF, 8'h00}, '{8'h7F, 8'hFF, 8'hF0}};

    initial begin
        forever #4 MCLK = ~MCLK;
    end

    frame_buffer_model frame_buffer_model_inst (.clk(MCLK), .rst(RST), .five(five), .retrace(retr),
        .strobe_n(stb_n), .planes(planes), .ovl_lo(lo), .ovl_hi(hi), .sync_n(sy_n), .blank_n(bl_n));
    palette_pixel_port #(.LANES(5), .PW(8)) palette_pixel_port_inst (.MCLK(MCLK), .RST(RST),
        .PIXEL_GROUP_LOAD_STROBE_N(stb_n), .PIXEL_PLANE_BITS(planes), .OVERLAY_SELECT_LOW(lo),
        .OVERLAY_SELECT_HIGH(hi), .SYNC_N(sy_n), .VIDEO_BLANK_INPUT_N(bl_n), .PSEL(PSEL),
        .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(prdata),
        .PREADY(rdy), .PSLVERR(err), .RED_CURRENT_OUTPUT(red), .GREEN_CURRENT_OUTPUT(green),
        .BLUE_CURRENT_OUTPUT(blue), .GREEN_SYNC_N(gsync_n), .DAC_BLANK_N(dblank_n));

    // ****************************************
    // reference model and bus tasks
    // ****************************************
    function automatic logic [23:0] pix(input logic [7:0] p, input logic l, input logic h);
        logic [1:0] o;
        logic [7:0] a;
        o = {h & cmd[1] & ~(cmd[3] & ~bon), l & cmd[0] & ~(cmd[2] & ~bon)};
        a = p & rm[7:0] & ~(bm[7:0] & {8{~bon}});
        return (cmd[6] && o == 2'b00) ? pal[a][23:0] : ovr[o][23:0];
    endfunction

    always @(posedge MCLK) begin
        cyc++;
        if (!chk) q.delete();
        else if (q.size() > 0 && q[0].due == cyc) begin
            `CHK("pixel colour", q[0].col, {red, green, blue})
            `CHK("green sync", q[0].sy, gsync_n)
            `CHK("blank level", q[0].bl, dblank_n)
            void'(q.pop_front());
        end
        // lane a leaves five edges after the capturing edge, the rest one per clock
        if (chk && !sp && stb_n)
            for (int i = 0; i < (cmd[7] ? 5 : 4); i++)
                q.push_back('{cyc + 5 + i, bl_n ? pix(planes[i * 8 +: 8], lo[i], hi[i]) : 24'h0,
                    sy_n, bl_n});
        sp = stb_n;
    end

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        PSEL <= 1;
        PENABLE <= 0;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge MCLK);
        PENABLE <= 1;
        // only the watchdog ends a wait for ready
        do begin
            @(posedge MCLK);
        end while (rdy !== 1'b1);
        rd = prdata;
        er = err;
        PSEL <= 0;
        PENABLE <= 0;
        @(posedge MCLK);
    endtask

    // settings change with checking off, then the load logic is given time to relock
    task automatic run(input int c, input int m, input int b);
        chk <= 0;
        @(posedge MCLK);
        cmd = c;
        rm = m;
        bm = b;
        apb(1, COMMAND_OFS, c);
        apb(1, READ_MASK_OFS, m);
        apb(1, BLINK_MASK_OFS, b);
        five <= c[MUX_RATIO_SELECT_POS];
        repeat (40) @(posedge MCLK);
        chk <= 1;
        repeat (300) @(posedge MCLK);
    endtask

    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    // ****************************************
    // main sequence and watchdog
    // ****************************************
    initial begin
        logic [7:0] rv [3];
        rv = '{READ_MASK_RST, BLINK_MASK_RST, COMMAND_RST};
        repeat (2) @(posedge MCLK);
        RST <= 0;
        @(posedge MCLK);
        for (int i = 0; i < 3; i++) begin
            apb(0, 12'(i * 4), 0);
            `CHK("reset value", {24'h0, rv[i]}, rd)
        end
        apb(0, 12'h020, 0);
        `CHK("unmapped error", 1'b1, er)
        `CHK("unmapped data", 32'h0, rd)
        apb(1, STATUS_OFS, 32'h3);
        `CHK("status write error", 1'b0, er)
        for (int i = 0; i < 256; i++) begin
            pal[i] = $random(seed) & 32'hFFFFFF;
            apb(1, PALETTE_BASE_OFS + 12'(i * 4), pal[i]);
        end
        for (int i = 0; i < 4; i++) begin
            ovr[i] = $random(seed) & 32'hFFFFFF;
            apb(1, OVERLAY_BASE_OFS + 12'(i * 4), ovr[i]);
        end
        apb(0, PALETTE_BASE_OFS + 12'h3FC, 0);
        `CHK("palette entry", 32'(pal[255]), rd)
        for (int c = 0; c < 5; c++) run(cfg[c][0], cfg[c][1], cfg[c][2]);
        chk <= 0;
        retr <= 1;
        repeat (960) @(posedge MCLK);
        apb(0, STATUS_OFS, 0);
        `CHK("retrace early", 1'b0, rd[RETRACE_STATUS_POS])
        `CHK("blink early", 1'b0, rd[BLINK_ON_STATUS_POS])
        repeat (88) @(posedge MCLK);
        apb(0, STATUS_OFS, 0);
        `CHK("retrace", 1'b1, rd[RETRACE_STATUS_POS])
        `CHK("blink on", 1'b1, rd[BLINK_ON_STATUS_POS])
        retr <= 0;
        bon = 1;
        run(8'hCF, 8'hFF, 8'hF0);
        wrap_up;
    end

    initial begin
        repeat (30000) @(posedge MCLK);
        n_errors++;
        wrap_up;
    end
endmodule // palette_pixel_port_test
`default_nettype wire
